// >>> hdl/pwm_cfg_pkg.sv
// Shared constants for the PWM clock, enable, mask and dead-zone configuration block
package pwm_cfg_pkg;
   // APB addressing: printed offsets are register indices, byte address is four times each
   localparam int APB_ADDR_W = 12;
   localparam logic [7:0] IDX_CLOCK_ENABLE_MASK = 8'ha1;
   localparam logic [7:0] IDX_MODE_DEADZONE = 8'ha7;
   localparam logic [APB_ADDR_W-1:0] ADDR_CLOCK_ENABLE_MASK =
      {2'h0, IDX_CLOCK_ENABLE_MASK, 2'h0};
   localparam logic [APB_ADDR_W-1:0] ADDR_MODE_DEADZONE = {2'h0, IDX_MODE_DEADZONE, 2'h0};

   // Values after reset
   localparam logic [7:0] RST_CLOCK_ENABLE_MASK = 8'h00;
   localparam logic [7:0] RST_MODE_DEADZONE = 8'h00;

   // Field positions, clock/enable/mask register
   localparam int POS_GROUP_CKS_HI = 7;
   localparam int POS_GROUP_CKS_LO = 6;
   localparam int POS_GROUP_EN = 5;
   localparam int POS_CH0_EN = 4;
   localparam int POS_CH0_CKS_HI = 3;
   localparam int POS_CH0_CKS_LO = 2;
   localparam int POS_NEG_MASK = 1;
   localparam int POS_POS_MASK = 0;

   // Field positions, mode/dead-zone register
   localparam int POS_BRIDGE_MODE = 7;
   localparam int POS_MASK_OUT_EN = 6;
   localparam int POS_OUT_MODE_HI = 5;
   localparam int POS_OUT_MODE_LO = 4;
   localparam int POS_DZ_HI = 3;
   localparam int POS_DZ_LO = 0;
   localparam int DZ_W = 4;

   // Clock source codes
   localparam logic [1:0] CKS_SYSCLK = 2'h0;
   localparam logic [1:0] CKS_RC_DIV = 2'h1;
   localparam logic [1:0] CKS_RC = 2'h2;
   localparam logic [1:0] CKS_RC_X2 = 2'h3;

   // Division of the oscillator for the slow source
   localparam int RC_DIVIDE = 256;
endpackage

// >>> hdl/pwm0_stage_if.sv
// Carrier between the configuration logic and the channel 0 output stage
`timescale 1ns/1ps
interface pwm0_stage_if;
   logic tick;
   logic run;
   logic half_bridge;
   logic [pwm_cfg_pkg::DZ_W-1:0] dead_zone;
   logic mask_en;
   logic pos_mask;
   logic neg_mask;
   logic clear;

   modport source (output tick, run, half_bridge, dead_zone, mask_en, pos_mask, neg_mask, clear);
   modport stage (input tick, run, half_bridge, dead_zone, mask_en, pos_mask, neg_mask, clear);
endinterface

// >>> hdl/pwm0_output_stage.sv
// Channel 0 complementary output stage with dead zone and mask override
`timescale 1ns/1ps
module pwm0_output_stage
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // Configuration
   pwm0_stage_if.stage cfg,
   // Raw waveform from the channel counter
   input wire logic i_wave,
   // Pin outputs
   output logic o_pos,
   output logic o_neg
);
   logic wave_q;
   logic [pwm_cfg_pkg::DZ_W-1:0] dz_cnt;
   logic [pwm_cfg_pkg::DZ_W-1:0] eff_dz;
   logic mask_on;
   logic edge_seen;

   // No dead zone in half-bridge mode, even if software left one set
   assign eff_dz = cfg.half_bridge ? '0 : cfg.dead_zone;
   assign mask_on = cfg.clear & cfg.mask_en;
   assign edge_seen = i_wave != wave_q;

   // Waveform history for edge detection
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         wave_q <= 1'b0;
      else if (!cfg.run)
         wave_q <= 1'b0;
      else
         wave_q <= i_wave;
   end

   // dead zone count
   // Counts modulator clock ticks, so the gap scales with the PWM clock
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         dz_cnt <= '0;
      else if (!cfg.run)
         dz_cnt <= '0;
      else if (edge_seen)
         dz_cnt <= eff_dz;
      else if (dz_cnt != '0 && cfg.tick)
         dz_cnt <= dz_cnt - 1'b1;
   end

   // turn-on delay
   // Unless the mask is on, both sides low on every edge, active side released once the count drains
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_pos <= 1'b0;
         o_neg <= 1'b0;
      end
      else if (mask_on)
      begin
         o_pos <= cfg.pos_mask;
         o_neg <= cfg.neg_mask;
      end
      else if (!cfg.run || edge_seen || dz_cnt != '0)
      begin
         o_pos <= 1'b0;
         o_neg <= 1'b0;
      end
      else
      begin
         o_pos <= wave_q;
         o_neg <= ~wave_q;
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);

   chk_mask_drives_pins: assert property (mask_on |=>
      o_pos == $past(cfg.pos_mask) && o_neg == $past(cfg.neg_mask))
      else $error("mask data not on pins");
   chk_mask_gated_off: assert property (!mask_on && !cfg.run |=> !o_pos && !o_neg)
      else $error("pins driven without mask or run");
   chk_dz_load: assert property (cfg.run && edge_seen |=> dz_cnt == $past(eff_dz))
      else $error("dead zone count not loaded");
   chk_dz_quiet: assert property (cfg.run && edge_seen && eff_dz != '0 && !mask_on
      ##1 !mask_on |=> !o_pos && !o_neg)
      else $error("output active inside dead zone");
   chk_no_overlap: assert property (!$past(mask_on) |-> !(o_pos && o_neg))
      else $error("both outputs active");
   cov_mask: cover property (mask_on ##1 o_neg);
   cov_dz_max: cover property (cfg.run && edge_seen && eff_dz == 4'hf);
endmodule

// >>> hdl/pwm_cfg_top.sv
// PWM clock source, enable, mask and dead-zone configuration with an APB register port
// Behaviour
// - Channel 0 clock from two-bit source selector
// - Channel 0 runs only while enable set
// - One shared enable runs channels 1-5
// - Mask enable forces pins while clear high
// - Negative pin mask bit 1, positive bit 0
// - Mode bit chooses normal or half-bridge
// - Two-bit field selects output modes 0-3
// - Dead zone is field times modulator clock period, none in half-bridge mode
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module pwm_cfg_top
#(
   parameter int RC_DIVIDE = pwm_cfg_pkg::RC_DIVIDE
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [pwm_cfg_pkg::APB_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Oscillator and channel inputs
   input wire logic i_internal_rc_oscillator,
   input wire logic i_ch0_clear_signal,
   input wire logic i_ch0_wave,
   // Modulator clock enables and run levels
   output logic o_ch0_modulator_clock,
   output logic o_group_modulator_clock,
   output logic o_ch0_run_enable,
   output logic o_group_run_enable,
   // Channel 0 mode and pins
   output logic o_ch0_bridge_mode,
   output logic [1:0] o_ch0_output_mode,
   output logic o_ch0_pos_output,
   output logic o_ch0_neg_output
);
   localparam int DIV_W = $clog2(RC_DIVIDE);

   // Divider must be a power of two of at least two
   if (RC_DIVIDE < 2 || (RC_DIVIDE & (RC_DIVIDE - 1)) != 0)
      $error("RC_DIVIDE must be a power of two of at least 2");

   logic [7:0] clock_enable_mask;
   logic [7:0] mode_deadzone;
   logic rc_s1;
   logic rc_s2;
   logic rc_s3;
   logic rc_rise;
   logic rc_fall;
   logic [DIV_W-1:0] rc_div;
   logic rc_div_tick;
   logic hit_clk;
   logic hit_mode;
   logic wr_take;
   logic [1:0] ch0_sel;
   logic [1:0] group_sel;

   pwm0_stage_if stage_bus ();

   // Source select, shared by both clock groups
   function automatic logic tick_of(input logic [1:0] sel, input logic rise,
                                    input logic fall, input logic slow);
      unique case (sel)
         pwm_cfg_pkg::CKS_SYSCLK: tick_of = 1'b1;
         pwm_cfg_pkg::CKS_RC_DIV: tick_of = slow;
         pwm_cfg_pkg::CKS_RC: tick_of = rise;
         pwm_cfg_pkg::CKS_RC_X2: tick_of = rise | fall;
      endcase
   endfunction

   // Address decode and bus handshake; zero wait states
   assign hit_clk = i_paddr == pwm_cfg_pkg::ADDR_CLOCK_ENABLE_MASK;
   assign hit_mode = i_paddr == pwm_cfg_pkg::ADDR_MODE_DEADZONE;
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~(hit_clk | hit_mode);
   assign wr_take = i_psel & i_penable & i_pwrite & i_pstrb[0];

   // Register writes; only byte lane 0 carries data
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         clock_enable_mask <= pwm_cfg_pkg::RST_CLOCK_ENABLE_MASK;
         mode_deadzone <= pwm_cfg_pkg::RST_MODE_DEADZONE;
      end
      else if (wr_take)
      begin
         if (hit_clk)
            clock_enable_mask <= i_pwdata[7:0];
         if (hit_mode)
            mode_deadzone <= i_pwdata[7:0];
      end
   end

   // Read data captured in the setup cycle so it comes from a flop
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_prdata <= 32'h0000_0000;
      else if (i_psel && !i_penable)
         o_prdata <= {24'h00_0000,
                      hit_clk ? clock_enable_mask : (hit_mode ? mode_deadzone : 8'h00)};
   end

   // Oscillator synchroniser; edges taken from the second and third flops only
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rc_s1 <= 1'b0;
         rc_s2 <= 1'b0;
         rc_s3 <= 1'b0;
      end
      else
      begin
         rc_s1 <= i_internal_rc_oscillator;
         rc_s2 <= rc_s1;
         rc_s3 <= rc_s2;
      end
   end
   assign rc_rise = rc_s2 & ~rc_s3;
   assign rc_fall = ~rc_s2 & rc_s3;

   // Oscillator divider; the oscillator must run below half the system clock
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         rc_div <= '0;
      else if (rc_rise)
         rc_div <= rc_div + 1'b1;
   end
   assign rc_div_tick = rc_rise && rc_div == DIV_W'(RC_DIVIDE - 1);

   assign ch0_sel = clock_enable_mask[pwm_cfg_pkg::POS_CH0_CKS_HI:pwm_cfg_pkg::POS_CH0_CKS_LO];
   assign group_sel =
      clock_enable_mask[pwm_cfg_pkg::POS_GROUP_CKS_HI:pwm_cfg_pkg::POS_GROUP_CKS_LO];
   assign o_ch0_run_enable = clock_enable_mask[pwm_cfg_pkg::POS_CH0_EN];
   assign o_group_run_enable = clock_enable_mask[pwm_cfg_pkg::POS_GROUP_EN];

   // channel 0 clock enable
   // Gated by the run bit so a stopped channel sees no ticks
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_ch0_modulator_clock <= 1'b0;
      else
         o_ch0_modulator_clock <= o_ch0_run_enable &
                                  tick_of(ch0_sel, rc_rise, rc_fall, rc_div_tick);
   end

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_group_modulator_clock <= 1'b0;
      else
         o_group_modulator_clock <= o_group_run_enable &
                                    tick_of(group_sel, rc_rise, rc_fall, rc_div_tick);
   end

   // mode fields straight from the register
   assign o_ch0_bridge_mode = mode_deadzone[pwm_cfg_pkg::POS_BRIDGE_MODE];
   assign o_ch0_output_mode =
      mode_deadzone[pwm_cfg_pkg::POS_OUT_MODE_HI:pwm_cfg_pkg::POS_OUT_MODE_LO];

   // Stage configuration
   assign stage_bus.tick = o_ch0_modulator_clock;
   assign stage_bus.run = o_ch0_run_enable;
   assign stage_bus.half_bridge = o_ch0_bridge_mode;
   assign stage_bus.dead_zone = mode_deadzone[pwm_cfg_pkg::POS_DZ_HI:pwm_cfg_pkg::POS_DZ_LO];
   assign stage_bus.mask_en = mode_deadzone[pwm_cfg_pkg::POS_MASK_OUT_EN];
   assign stage_bus.pos_mask = clock_enable_mask[pwm_cfg_pkg::POS_POS_MASK];
   assign stage_bus.neg_mask = clock_enable_mask[pwm_cfg_pkg::POS_NEG_MASK];
   assign stage_bus.clear = i_ch0_clear_signal;

   pwm0_output_stage pwm0_output_stage_i
   (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .cfg(stage_bus),
      .i_wave(i_ch0_wave),
      .o_pos(o_ch0_pos_output),
      .o_neg(o_ch0_neg_output)
   );

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);

   chk_sysclk_every_cycle: assert property (o_ch0_run_enable && ch0_sel == 2'h0 |=>
      o_ch0_modulator_clock)
      else $error("system clock source missed a tick");
   chk_rc_edge_tick: assert property (ch0_sel == 2'h2 && o_ch0_run_enable |=>
      o_ch0_modulator_clock == $past(rc_rise))
      else $error("oscillator source tick wrong");
   chk_group_double: assert property (group_sel == 2'h3 && o_group_run_enable |=>
      o_group_modulator_clock == $past(rc_rise | rc_fall))
      else $error("doubled source tick wrong");
   chk_ch0_stopped: assert property (!o_ch0_run_enable |=> !o_ch0_modulator_clock)
      else $error("channel 0 ticks while disabled");
   chk_group_stopped: assert property (!o_group_run_enable |=> !o_group_modulator_clock)
      else $error("group ticks while disabled");
   chk_bridge_write: assert property (wr_take && hit_mode |=>
      o_ch0_bridge_mode == $past(i_pwdata[7]))
      else $error("bridge mode not written");
   chk_out_mode_write: assert property (wr_take && hit_mode |=>
      o_ch0_output_mode == $past(i_pwdata[5:4]))
      else $error("output mode not written");

   // Register fields reach their users one cycle after the write
   chk_ch0_run_write: assert property (wr_take && hit_clk |=>
      o_ch0_run_enable == $past(i_pwdata[4]))
      else $error("channel 0 run bit not written");
   chk_group_run_write: assert property (wr_take && hit_clk |=>
      o_group_run_enable == $past(i_pwdata[5]))
      else $error("group run bit not written");
   chk_ch0_src_write: assert property (wr_take && hit_clk |=>
      ch0_sel == $past(i_pwdata[3:2]))
      else $error("channel 0 source not written");
   chk_group_src_write: assert property (wr_take && hit_clk |=>
      group_sel == $past(i_pwdata[7:6]))
      else $error("group source not written");
   chk_dz_write: assert property (wr_take && hit_mode |=>
      stage_bus.dead_zone == $past(i_pwdata[3:0]))
      else $error("dead zone not written");

   cov_rc_div: cover property (ch0_sel == 2'h1 && o_ch0_run_enable && rc_div_tick ##1
      o_ch0_modulator_clock);
   cov_bad_addr: cover property (o_pslverr);
endmodule

// >>> tb/pwm_cfg_top_test.sv
// Self-checking bench for the PWM configuration block
`timescale 1ns/1ps
module pwm_cfg_top_test;
   logic i_clock;
   logic i_reset_n;
   logic psel, penable, pwrite, pready, pslverr, osc, clr, wave, err;
   logic ch0_clk, grp_clk, ch0_run, grp_run, bridge, pos, neg;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [1:0] omode;
   int error_cnt = 0;
   int samples_checked = 0;
   int osc_div = 0;
   localparam logic [11:0] A_CLK = pwm_cfg_pkg::ADDR_CLOCK_ENABLE_MASK;
   localparam logic [11:0] A_MODE = pwm_cfg_pkg::ADDR_MODE_DEADZONE;

   // Divider shortened so the slow source shows a few ticks per window
   pwm_cfg_top #(.RC_DIVIDE(4)) pwm_cfg_top_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_internal_rc_oscillator(osc), .i_ch0_clear_signal(clr),
      .i_ch0_wave(wave), .o_ch0_modulator_clock(ch0_clk), .o_group_modulator_clock(grp_clk),
      .o_ch0_run_enable(ch0_run), .o_group_run_enable(grp_run), .o_ch0_bridge_mode(bridge),
      .o_ch0_output_mode(omode), .o_ch0_pos_output(pos), .o_ch0_neg_output(neg));

   // System clock, 10 ns period
   initial
   begin
      i_clock = 1'h0;
      forever #5 i_clock = ~i_clock;
   end

   // Oscillator at one eighth of the system clock, well under the half-rate limit
   always @(posedge i_clock)
   begin
      osc_div <= osc_div + 1;
      osc <= osc_div[2];
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_range(input int got, input int lo, input int hi);
      samples_checked++;
      if (got < lo || got > hi)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask

   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge i_clock);
      penable <= 1'h1;
      @(posedge i_clock);
      while (pready !== 1'h1 && n < 50)
      begin
         @(posedge i_clock);
         n++;
      end
      if (n == 50)
         error_cnt++;
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge i_clock);
   endtask

   task automatic test_refusals();
      apb(1'h0, A_CLK, 8'h00);
      check(rd, {24'h00_0000, pwm_cfg_pkg::RST_CLOCK_ENABLE_MASK});
      check(err, 32'h0000_0000);
      apb(1'h0, A_MODE, 8'h00);
      check(rd, {24'h00_0000, pwm_cfg_pkg::RST_MODE_DEADZONE});
      apb(1'h1, 12'h288, 8'hff);
      check(err, 32'h0000_0001);
      apb(1'h0, 12'h288, 8'h00);
      check(err, 32'h0000_0001);
      check(rd, 32'h0000_0000);
      pstrb <= 4'h0;
      apb(1'h1, A_MODE, 8'hff);
      pstrb <= 4'h1;
      apb(1'h0, A_MODE, 8'h00);
      check(rd, 32'h0000_0000);
   endtask

   task automatic test_modes();
      logic [7:0] v;
      for (int i = 0; i < 8; i++)
      begin
         v = {i[2], 1'h0, i[1:0], 4'h0};
         apb(1'h1, A_MODE, v);
         check(omode, i[1:0]);
         check(bridge, i[2]);
         apb(1'h0, A_MODE, 8'h00);
         check(rd, {24'h00_0000, v});
      end
   endtask

   task automatic test_run_enables();
      logic [7:0] vals [4] = '{8'h10, 8'h20, 8'h30, 8'h00};
      foreach (vals[i])
      begin
         apb(1'h1, A_CLK, vals[i]);
         check(ch0_run, vals[i][4]);
         check(grp_run, vals[i][5]);
         apb(1'h0, A_CLK, 8'h00);
         check(rd, {24'h00_0000, vals[i]});
      end
   endtask

   // Count ticks of both clock enables over 96 cycles for each source, then with runs off
   task automatic test_clock_sources();
      int exp [5] = '{96, 3, 12, 24, 0};
      logic [7:0] v;
      int c0, c1;
      for (int s = 0; s < 5; s++)
      begin
         v = (s < 4) ? {s[1:0], 2'h3, s[1:0], 2'h0} : 8'hcc;
         apb(1'h1, A_CLK, v);
         repeat (8) @(posedge i_clock);
         c0 = 0;
         c1 = 0;
         repeat (96)
         begin
            @(posedge i_clock);
            c0 += int'(ch0_clk === 1'h1);
            c1 += int'(grp_clk === 1'h1);
         end
         check_range(c0, exp[s] - 1, exp[s] + 1);
         check_range(c1, exp[s] - 1, exp[s] + 1);
      end
   endtask

   task automatic test_mask();
      apb(1'h1, A_MODE, 8'h40);
      apb(1'h1, A_CLK, 8'h02);
      clr <= 1'h1;
      repeat (3) @(posedge i_clock);
      check({pos, neg}, 32'h0000_0001);
      apb(1'h1, A_CLK, 8'h01);
      repeat (3) @(posedge i_clock);
      check({pos, neg}, 32'h0000_0002);
      clr <= 1'h0;
      repeat (3) @(posedge i_clock);
      check({pos, neg}, 32'h0000_0000);
   endtask

   // Cycles from a wave edge until the active side turns on
   task automatic measure(input int dz, input logic lvl);
      int k;
      k = 0;
      wave <= lvl;
      do
      begin
         @(posedge i_clock);
         k++;
         if ((pos & neg) === 1'h1)
            check({pos, neg}, 32'h0000_0000);
      end while ((lvl ? pos : neg) !== 1'h1 && k < 40);
      check_range(k, dz + 2, dz + 4);
      check(lvl ? neg : pos, 32'h0000_0000);
   endtask

   task automatic test_dead_zone();
      apb(1'h1, A_CLK, 8'h10);
      apb(1'h1, A_MODE, 8'h00);
      repeat (20) @(posedge i_clock);
      check({pos, neg}, 32'h0000_0001);
      measure(0, 1'h1);
      measure(0, 1'h0);
      apb(1'h1, A_MODE, 8'h0f);
      measure(15, 1'h1);
      measure(15, 1'h0);
   endtask

   // Reset in mid-run returns the registers and the pins to rest
   task automatic test_mid_reset();
      apb(1'h1, A_CLK, 8'hff);
      i_reset_n <= 1'h0;
      repeat (3) @(posedge i_clock);
      check({ch0_run, grp_run, pos, neg}, 32'h0000_0000);
      i_reset_n <= 1'h1;
      @(posedge i_clock);
      apb(1'h0, A_CLK, 8'h00);
      check(rd, {24'h00_0000, pwm_cfg_pkg::RST_CLOCK_ENABLE_MASK});
   endtask

   task automatic summarize();
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Watchdog, far beyond the fewer than one thousand cycles the tests need
   initial
   begin
      #100_000;
      error_cnt++;
      summarize();
   end

   initial
   begin
      i_reset_n = 1'h0;
      {psel, penable, pwrite, clr, wave} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h1;
      repeat (3) @(posedge i_clock);
      i_reset_n <= 1'h1;
      @(posedge i_clock);
      test_refusals();
      test_modes();
      test_run_enables();
      test_clock_sources();
      test_mask();
      test_dead_zone();
      test_mid_reset();
      summarize();
   end
endmodule
